// File: inc/dafm_pkg.sv
// constants, record layout and carriers for the drive fault manager
// assumes a 10 MHz system clock and a word-wide plain register port
package dafm_pkg;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int NS_PER_MS      = 1000000;

  // indicator blink half period and link watchdog, in milliseconds
  localparam int BLINK_HALF_MS  = 250;
  localparam int WDOG_MS        = 100;
  localparam int TICK_MS        = 1;
  // all times round down to whole cycles; nothing holds them at one cycle or more
  localparam int BLINK_HALF_CYC = (BLINK_HALF_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int WDOG_CYC       = (WDOG_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int TICK_CYC       = (TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;

  localparam int HIST_DEPTH     = 10;

  // register offsets on the plain port
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_HIST_SEL = 8'h08;
  localparam logic [7:0] OFS_REC_BASE = 8'h0C;
  localparam int         REC_WORDS    = 8;

  // command register bits
  localparam int CMD_ALM_RESET_BIT  = 0;
  localparam int CMD_HIST_CLEAR_BIT = 1;

  // status register fields
  localparam int ST_ALARM_BIT   = 0;
  localparam int ST_PCO_BIT     = 1;
  localparam int ST_TIMEOUT_BIT = 2;
  localparam int ST_NOCFG_BIT   = 3;
  localparam int ST_BADCFG_BIT  = 4;
  localparam int ST_CODE_LSB    = 8;
  localparam int ST_SUB_LSB     = 16;
  localparam int ST_CNT_LSB     = 24;

  localparam logic [7:0]  OPE_DATA_ERR_CODE = 8'h70;
  localparam logic [15:0] OPINFO0_UNUSED    = 16'hFFFF;
  localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;

  typedef enum logic [1:0] {NET_IDLE, NET_RUN, NET_LOST} dafm_net_t;

  typedef struct packed {
    logic red;
    logic green;
  } dafm_led_t;

  // alarm raised by the detectors elsewhere in the drive
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] sub;
    logic       power_cycle_only;
    logic       abs_pos_error;
  } dafm_alarm_t;

  // live drive state sampled into a record
  typedef struct packed {
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [15:0] phys_in;
    logic [7:0]  remote_out;
    logic        op_data_used;
    logic [7:0]  op_data_num;
    logic [7:0]  op_type;
    logic [31:0] fb_pos;
  } dafm_snap_t;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  sub;
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [15:0] phys_in;
    logic [7:0]  remote_out;
    logic [15:0] opinfo0;
    logic [7:0]  opinfo1;
    logic [31:0] fb_pos;
    logic [31:0] t_boot;
    logic [31:0] t_op;
    logic [31:0] t_main;
  } dafm_rec_t;

endpackage

// File: logic/dafm_blink.sv
// square-wave blink phase for the status indicators
// assumes one system clock; restart forces the lit half to begin now
`timescale 1ns/1ns
module dafm_blink #(
  parameter int HALF_CYC = dafm_pkg::BLINK_HALF_CYC
) (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic restart,
  output logic      blink_on
);

  logic [31:0] cnt_r;
  logic        at_end;

  assign at_end = (cnt_r >= 32'(HALF_CYC - 1));

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r    <= 32'h0000_0000;
      blink_on <= 1'b1;
    end else if (restart) begin
      cnt_r    <= 32'h0000_0001;
      blink_on <= 1'b1;
    end else if (at_end) begin
      cnt_r    <= 32'h0000_0000;
      blink_on <= ~blink_on;
    end else begin
      cnt_r    <= cnt_r + 32'h0000_0001;
    end
  end

endmodule // dafm_blink

// File: logic/dafm_fault_mgr.sv
// drive fault manager: link watchdog, settings check, alarm latch, history
// assumes synchronous inputs, detectors pulse alarm.valid for one cycle
//
// Notes on behaviour
// RULE_01 - cyclic exchange stops: timeout, network indicator blinks red
// RULE_02 - link back: timeout clears, network indicator green
// RULE_03 - no settings loaded: module indicator blinks green
// RULE_04 - corrupt settings: module indicator blinks red
// RULE_05 - valid settings complete: module indicator steady green
// RULE_06 - host reinitialises settings, power cycles, reloads
// RULE_07 - alarm: fault outputs flip, motor stops
// RULE_08 - power indicator blinks red with alarm outputs
// RULE_09 - clear input acts on rising edge only
// RULE_10 - network command, tool or power cycle clear
// RULE_11 - power-cycle-only alarms ignore other clears
// RULE_12 - preset or homing done clears position error
// RULE_13 - ten records newest first, oldest dropped
// RULE_14 - host reads stored records through monitor access
// RULE_15 - maintenance command empties the whole history
// RULE_16 - record holds codes, temperatures, inverter voltage
// RULE_17 - operation data error sub code kept verbatim
// RULE_18 - record holds 16-bit physical input snapshot
// RULE_19 - record holds 8-bit remote output snapshot
// RULE_20 - record holds data number, operation type, position
// RULE_21 - record holds three elapsed-time counts
// RULE_22 - remote outputs sampled without network too
// RULE_23 - only numeric record fields readable
// RULE_24 - data number reads -1 when unused
// RULE_25 - alarm stays latched until valid reset
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
module dafm_fault_mgr #(
  parameter int BLINK_HALF_CYC = dafm_pkg::BLINK_HALF_CYC,
  parameter int WDOG_CYC       = dafm_pkg::WDOG_CYC,
  parameter int TICK_CYC       = dafm_pkg::TICK_CYC
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_N,
  input  wire logic                  HIST_RST_N,
  input  wire logic [7:0]            ADDR,
  input  wire logic [31:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [31:0]                RDATA,
  input  wire logic                  PD_STROBE,
  input  wire logic                  CFG_LOADED,
  input  wire logic                  CFG_CORRUPT,
  input  wire dafm_pkg::dafm_alarm_t ALARM,
  input  wire logic                  FAULT_CLEAR_IN,
  input  wire logic                  TOOL_RESET,
  input  wire logic                  PRESET_DONE,
  input  wire logic                  HOME_DONE,
  input  wire logic                  OP_START,
  input  wire logic                  MAIN_PWR_ON,
  input  wire dafm_pkg::dafm_snap_t  SNAP,
  output logic                       FAULT_FLAG_OUT,
  output logic                       FAULT_FLAG_INVERTED_OUT,
  output logic                       MOTOR_STOP,
  output dafm_pkg::dafm_led_t        NETWORK_STATE_INDICATOR,
  output dafm_pkg::dafm_led_t        MODULE_STATE_INDICATOR,
  output dafm_pkg::dafm_led_t        POWER_FAULT_INDICATOR
);

  // pick one numeric word of a record; no text is ever stored
  function automatic logic [31:0] rec_word(input dafm_pkg::dafm_rec_t r,
                                           input logic [2:0] idx);
    case (idx)
      3'h0:    rec_word = {8'h00, r.opinfo1, r.sub, r.code};
      3'h1:    rec_word = {r.mot_temp, r.drv_temp};
      3'h2:    rec_word = {r.phys_in, r.inv_volt};
      3'h3:    rec_word = {8'h00, r.remote_out, r.opinfo0};
      3'h4:    rec_word = r.fb_pos;
      3'h5:    rec_word = r.t_boot;
      3'h6:    rec_word = r.t_op;
      3'h7:    rec_word = r.t_main;
      default: rec_word = dafm_pkg::WORD_ZERO;
    endcase
  endfunction

  // ---------------- link watchdog and indicators ----------------
  dafm_pkg::dafm_net_t net_r;
  dafm_pkg::dafm_net_t net_nxt;
  logic [31:0]         wdog_r;
  logic                wdog_hit;
  logic                blink_free;
  logic                blink_alm;
  logic                alm_raise;

  assign wdog_hit = (wdog_r >= 32'(WDOG_CYC - 1));

  always_comb begin
    net_nxt = net_r;
    case (net_r)
      dafm_pkg::NET_IDLE: if (PD_STROBE) net_nxt = dafm_pkg::NET_RUN;
      dafm_pkg::NET_RUN:  if (!PD_STROBE && wdog_hit) net_nxt = dafm_pkg::NET_LOST; // RULE_01
      dafm_pkg::NET_LOST: if (PD_STROBE) net_nxt = dafm_pkg::NET_RUN; // RULE_02
      default:            net_nxt = dafm_pkg::NET_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      net_r  <= dafm_pkg::NET_IDLE;
      wdog_r <= 32'h0000_0000;
    end else begin
      net_r  <= net_nxt;
      wdog_r <= (PD_STROBE || wdog_hit) ? 32'h0000_0000 : wdog_r + 32'h0000_0001;
    end
  end

  dafm_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink_free (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .restart  (1'b0),
    .blink_on (blink_free)
  );

  // alarm blink restarts so its lit half lines up with the outputs
  dafm_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink_alm (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .restart  (alm_raise),
    .blink_on (blink_alm)
  );

  dafm_pkg::dafm_led_t net_led_nxt;
  dafm_pkg::dafm_led_t mod_led_nxt;

  assign net_led_nxt.red   = (net_nxt == dafm_pkg::NET_LOST) && blink_free; // RULE_01
  assign net_led_nxt.green = (net_nxt == dafm_pkg::NET_RUN); // RULE_02
  // corruption outranks missing settings: reload alone cannot fix it
  assign mod_led_nxt.red   = CFG_CORRUPT && blink_free; // RULE_04
  assign mod_led_nxt.green = !CFG_CORRUPT && (CFG_LOADED || blink_free); // RULE_03 RULE_05

  // ---------------- alarm latch ----------------
  logic       alm_r;
  logic       alm_nxt;
  logic       pco_r;
  logic       abs_r;
  logic [7:0] code_r;
  logic [7:0] sub_r;
  logic       clr_prev_r;
  logic       clr_edge;
  logic       cmd_rst;
  logic       soft_clear;
  logic       abs_clear;
  logic       clear_req;
  logic       wr_cmd;

  assign wr_cmd     = WR && (ADDR == dafm_pkg::OFS_CMD);
  assign cmd_rst    = wr_cmd && WDATA[dafm_pkg::CMD_ALM_RESET_BIT];
  assign clr_edge   = FAULT_CLEAR_IN && !clr_prev_r; // RULE_09
  assign soft_clear = (clr_edge || cmd_rst || TOOL_RESET) && !pco_r; // RULE_10 RULE_11
  assign abs_clear  = abs_r && !pco_r && (PRESET_DONE || HOME_DONE); // RULE_12
  assign clear_req  = alm_r && (soft_clear || abs_clear);
  assign alm_raise  = ALARM.valid && !alm_r;
  // a new alarm wins over a clear in the same cycle
  assign alm_nxt    = ALARM.valid || (alm_r && !clear_req); // RULE_25

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      alm_r      <= 1'b0;
      pco_r      <= 1'b0;
      abs_r      <= 1'b0;
      code_r     <= 8'h00;
      sub_r      <= 8'h00;
      clr_prev_r <= 1'b0;
    end else begin
      alm_r      <= alm_nxt;
      clr_prev_r <= FAULT_CLEAR_IN;
      if (ALARM.valid) begin
        code_r <= ALARM.code;
        sub_r  <= ALARM.sub;
        pco_r  <= ALARM.power_cycle_only || (alm_r && pco_r); // RULE_11
        abs_r  <= ALARM.abs_pos_error || (alm_r && abs_r);
      end else if (!alm_nxt) begin
        pco_r  <= 1'b0;
        abs_r  <= 1'b0;
      end
    end
  end

  // registered outputs; fault outputs, motor stop and power indicator all fed by alm_nxt
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_FLAG_OUT          <= 1'b0;
      FAULT_FLAG_INVERTED_OUT <= 1'b1;
      MOTOR_STOP              <= 1'b0;
      POWER_FAULT_INDICATOR   <= '{red: 1'b0, green: 1'b1};
      NETWORK_STATE_INDICATOR <= '{red: 1'b0, green: 1'b0};
      MODULE_STATE_INDICATOR  <= '{red: 1'b0, green: 1'b0};
    end else begin
      FAULT_FLAG_OUT          <= alm_nxt; // RULE_07
      FAULT_FLAG_INVERTED_OUT <= !alm_nxt; // RULE_07
      MOTOR_STOP              <= alm_nxt; // RULE_07
      POWER_FAULT_INDICATOR.red   <= alm_nxt && (alm_raise || blink_alm); // RULE_08
      POWER_FAULT_INDICATOR.green <= !alm_nxt;
      NETWORK_STATE_INDICATOR <= net_led_nxt;
      MODULE_STATE_INDICATOR  <= mod_led_nxt;
    end
  end

  // ---------------- elapsed-time counters ----------------
  logic [31:0] tick_r;
  logic        tick;
  logic [31:0] t_boot_r;
  logic [31:0] t_op_r;
  logic [31:0] t_main_r;
  logic        op_used_r;
  logic [7:0]  op_num_r;

  assign tick = (tick_r >= 32'(TICK_CYC - 1));

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tick_r    <= 32'h0000_0000;
      t_boot_r  <= 32'h0000_0000;
      t_op_r    <= 32'h0000_0000;
      t_main_r  <= 32'h0000_0000;
      op_used_r <= 1'b0;
      op_num_r  <= 8'h00;
    end else begin
      tick_r   <= tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
      t_boot_r <= t_boot_r + {31'h0000_0000, tick}; // RULE_21
      if (OP_START) t_op_r <= 32'h0000_0000;
      else          t_op_r <= t_op_r + {31'h0000_0000, tick};
      if (!MAIN_PWR_ON) t_main_r <= 32'h0000_0000;
      else              t_main_r <= t_main_r + {31'h0000_0000, tick};
      // the last number run is held while stopped
      if (OP_START) begin
        op_used_r <= SNAP.op_data_used;
        op_num_r  <= SNAP.op_data_num;
      end
    end
  end

  // ---------------- alarm history ----------------
  dafm_pkg::dafm_rec_t hist_mem [dafm_pkg::HIST_DEPTH];
  dafm_pkg::dafm_rec_t new_rec;
  logic [3:0]          hist_cnt_r;
  logic                hist_clr;

  assign hist_clr = wr_cmd && WDATA[dafm_pkg::CMD_HIST_CLEAR_BIT];

  assign new_rec.code       = ALARM.code; // RULE_16
  assign new_rec.sub        = ALARM.sub; // RULE_17
  assign new_rec.drv_temp   = SNAP.drv_temp; // RULE_16
  assign new_rec.mot_temp   = SNAP.mot_temp;
  assign new_rec.inv_volt   = SNAP.inv_volt;
  assign new_rec.phys_in    = SNAP.phys_in; // RULE_18
  // taken from the internal image, link or not
  assign new_rec.remote_out = SNAP.remote_out; // RULE_19 RULE_22
  assign new_rec.opinfo0    = op_used_r ? {8'h00, op_num_r}
                                        : dafm_pkg::OPINFO0_UNUSED; // RULE_24
  assign new_rec.opinfo1    = SNAP.op_type; // RULE_20
  assign new_rec.fb_pos     = SNAP.fb_pos; // RULE_20
  assign new_rec.t_boot     = t_boot_r; // RULE_21
  assign new_rec.t_op       = t_op_r;
  assign new_rec.t_main     = t_main_r;

  // storage survives the control reset; only its own reset or the history clear command empties it
  always_ff @(posedge CLK_SYS) begin
    if (ALARM.valid) begin
      for (int i = dafm_pkg::HIST_DEPTH - 1; i > 0; i--) begin
        hist_mem[i] <= hist_mem[i-1]; // RULE_13
      end
      hist_mem[0] <= new_rec;
    end
  end

  always_ff @(posedge CLK_SYS or negedge HIST_RST_N) begin
    if (!HIST_RST_N) begin
      hist_cnt_r <= 4'h0;
    end else if (ALARM.valid) begin
      // capture beats an erase in the same cycle
      if (hist_clr)
        hist_cnt_r <= 4'h1;
      else if (hist_cnt_r < 4'(dafm_pkg::HIST_DEPTH))
        hist_cnt_r <= hist_cnt_r + 4'h1; // RULE_13
    end else if (hist_clr) begin
      hist_cnt_r <= 4'h0; // RULE_15
    end
  end

  // ---------------- register port ----------------
  logic [3:0]  sel_r;
  logic [7:0]  rec_ofs;
  logic        rec_hit;
  logic        sel_valid;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign rec_ofs   = ADDR - dafm_pkg::OFS_REC_BASE;
  assign rec_hit   = (ADDR >= dafm_pkg::OFS_REC_BASE) && (ADDR[1:0] == 2'h0)
                     && (rec_ofs[7:2] < 6'(dafm_pkg::REC_WORDS));
  assign sel_valid = (sel_r < hist_cnt_r);

  assign status_word = {4'h0, hist_cnt_r, sub_r, code_r, 3'h0,
                        CFG_CORRUPT, !CFG_LOADED,
                        (net_r == dafm_pkg::NET_LOST), pco_r, alm_r};

  // unselected, empty or unmapped reads return zero
  assign rd_word = (ADDR == dafm_pkg::OFS_STATUS)   ? status_word :
                   (ADDR == dafm_pkg::OFS_HIST_SEL) ? {28'h000_0000, sel_r} :
                   (rec_hit && sel_valid)           ? rec_word(hist_mem[sel_r], rec_ofs[4:2]) :
                   dafm_pkg::WORD_ZERO; // RULE_14 RULE_23

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sel_r <= 4'h0;
      RDATA <= 32'h0000_0000;
    end else begin
      if (WR && ADDR == dafm_pkg::OFS_HIST_SEL) sel_r <= WDATA[3:0];
      RDATA <= RD ? rd_word : 32'h0000_0000; // RULE_14
    end
  end

  // ---------------- assertions ----------------
  sequence seq_link_lost_then_back;
    (net_r == dafm_pkg::NET_LOST) && PD_STROBE;
  endsequence

  sequence seq_new_alarm;
    ALARM.valid && !alm_r;
  endsequence

  AST_TIMEOUT_BLINK: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_01
    (net_r == dafm_pkg::NET_LOST) && !PD_STROBE |=> !NETWORK_STATE_INDICATOR.green)
    else $error("network indicator green during timeout");

  AST_RECONNECT: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_02
    seq_link_lost_then_back |=> (net_r == dafm_pkg::NET_RUN)
      && NETWORK_STATE_INDICATOR.green && !NETWORK_STATE_INDICATOR.red)
    else $error("timeout not cleared on reconnect");

  AST_MS_BAD: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_04
    CFG_CORRUPT |=> !MODULE_STATE_INDICATOR.green)
    else $error("module indicator green with corrupt settings");

  AST_MS_OK: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_05
    CFG_LOADED && !CFG_CORRUPT |=> MODULE_STATE_INDICATOR.green && !MODULE_STATE_INDICATOR.red)
    else $error("module indicator not steady green");

  AST_ALM_OUT: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_07
    ALARM.valid |=> FAULT_FLAG_OUT && !FAULT_FLAG_INVERTED_OUT && MOTOR_STOP)
    else $error("alarm outputs not asserted");

  AST_ALM_LED: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_08
    seq_new_alarm |=> POWER_FAULT_INDICATOR.red && FAULT_FLAG_OUT)
    else $error("power indicator not red with alarm");

  AST_EDGE_ONLY: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_09
    alm_r && FAULT_CLEAR_IN && $past(FAULT_CLEAR_IN) && !cmd_rst && !TOOL_RESET
      && !PRESET_DONE && !HOME_DONE |=> alm_r)
    else $error("steady clear level reset an alarm");

  AST_PCO_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_11
    alm_r && pco_r |=> alm_r)
    else $error("power-cycle-only alarm cleared");

  AST_LATCH: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE_25
    alm_r && !(clr_edge || cmd_rst || TOOL_RESET || PRESET_DONE || HOME_DONE)
      |=> alm_r && FAULT_FLAG_OUT)
    else $error("alarm dropped without reset");

  AST_HIST_CAP: assert property (@(posedge CLK_SYS) disable iff (!HIST_RST_N) // RULE_13
    ALARM.valid && !hist_clr && hist_cnt_r < 4'hA |=> hist_cnt_r == $past(hist_cnt_r) + 4'h1)
    else $error("history count did not advance");

  AST_HIST_CLR: assert property (@(posedge CLK_SYS) disable iff (!HIST_RST_N) // RULE_15
    hist_clr && !ALARM.valid |=> hist_cnt_r == 4'h0)
    else $error("history not emptied");

endmodule // dafm_fault_mgr

// File: verif/dafm_host_model.sv
// host controller side of the drive: cyclic process-data strobes
// assumes the drive samples pd_strobe on the rising edge of CLK_SYS
`timescale 1ns/1ns
module dafm_host_model #(
  parameter int PERIOD = 5
) (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic run,
  output logic      pd_strobe
);
  int cnt_r;
  // a pulled cable just goes quiet: no strobes while run is low
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r     <= 0;
      pd_strobe <= 1'b0;
    end else begin
      cnt_r     <= (run && cnt_r < PERIOD - 1) ? cnt_r + 1 : 0;
      pd_strobe <= run && cnt_r == PERIOD - 1;
    end
  end
endmodule // dafm_host_model

// File: verif/drive_alarm_fault_manager_test.sv
// self-checking bench for the drive fault manager
// assumes the host model supplies process-data strobes; registers via the plain port
`timescale 1ns/1ns
module drive_alarm_fault_manager_test;
  localparam int HALF = 4;
  localparam int WDOG = 20;
  logic                  clk_sys = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  hist_rst_n = 1'b0;
  logic [7:0]            addr = 8'h00;
  logic [31:0]           wdata = 32'h0, rdata;
  logic                  wr = 1'b0, rd = 1'b0, pd_strobe, host_run = 1'b0;
  logic                  cfg_loaded = 1'b1, cfg_corrupt = 1'b0, fault_clear_in = 1'b0;
  logic                  tool_reset = 1'b0, preset_done = 1'b0, home_done = 1'b0;
  logic                  op_start = 1'b0, main_pwr_on = 1'b1;
  dafm_pkg::dafm_alarm_t alarm = '0;
  dafm_pkg::dafm_snap_t  snap = '0;
  logic                  flag, flag_n, stop;
  dafm_pkg::dafm_led_t   net_led, mod_led, pwr_led;
  int                    miscompares = 0, tests_run = 0;

  always #50 clk_sys = ~clk_sys;

  dafm_fault_mgr #(.BLINK_HALF_CYC(HALF), .WDOG_CYC(WDOG), .TICK_CYC(3)) i_dafm_fault_mgr (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .HIST_RST_N(hist_rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PD_STROBE(pd_strobe),
    .CFG_LOADED(cfg_loaded), .CFG_CORRUPT(cfg_corrupt), .ALARM(alarm),
    .FAULT_CLEAR_IN(fault_clear_in), .TOOL_RESET(tool_reset), .PRESET_DONE(preset_done),
    .HOME_DONE(home_done), .OP_START(op_start), .MAIN_PWR_ON(main_pwr_on), .SNAP(snap),
    .FAULT_FLAG_OUT(flag), .FAULT_FLAG_INVERTED_OUT(flag_n), .MOTOR_STOP(stop),
    .NETWORK_STATE_INDICATOR(net_led), .MODULE_STATE_INDICATOR(mod_led),
    .POWER_FAULT_INDICATOR(pwr_led));

  dafm_host_model i_dafm_host_model (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .run(host_run), .pd_strobe(pd_strobe));

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic alm(input logic [7:0] c, s, input logic pco, ab);
    @(posedge clk_sys);
    alarm <= '{1'b1, c, s, pco, ab};
    @(posedge clk_sys);
    alarm.valid <= 1'b0;
    cyc(1);
  endtask

  // 0 tool reset, 1 preset done, 2 homing done, 3 operation start
  task automatic pulse(input int w);
    @(posedge clk_sys);
    {tool_reset, preset_done, home_done, op_start} <= 4'h8 >> w;
    @(posedge clk_sys);
    {tool_reset, preset_done, home_done, op_start} <= 4'h0;
    cyc(2);
  endtask

  task automatic pwr_cycle;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    cyc(2);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(2);
  endtask

  // counts lit cycles over one blink period: steady gives 2*HALF, blinking HALF
  task automatic lit(input int w, output int r, output int g);
    dafm_pkg::dafm_led_t l;
    r = 0;
    g = 0;
    repeat (2 * HALF) begin
      cyc(1);
      l = (w == 0) ? net_led : (w == 1) ? mod_led : pwr_led;
      r += l.red;
      g += l.green;
    end
  endtask

  task automatic t_reset;
    logic [31:0] v;
    chk({flag, flag_n, stop}, 3'b010);
    chk(pwr_led, 2'b01);
    chk(net_led, 2'b00);
    rd_reg(8'hFC, v);
    chk(v, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_link;
    int r, g;
    logic [31:0] v;
    host_run <= 1'b1;
    cyc(12);
    lit(0, r, g);
    chk({r[15:0], g[15:0]}, {16'd0, 16'd8});
    host_run <= 1'b0;
    cyc(WDOG + 5);
    lit(0, r, g);
    chk({r[15:0], g[15:0]}, {16'(HALF), 16'd0});
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[2], 1'b1);
    host_run <= 1'b1;
    cyc(8);
    lit(0, r, g);
    chk({r[15:0], g[15:0]}, {16'd0, 16'd8});
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[2], 1'b0);
    host_run <= 1'b0;
    $display("test link done");
  endtask

  task automatic t_cfg;
    int r, g;
    cfg_loaded <= 1'b0;
    cyc(2);
    lit(1, r, g);
    chk({r[15:0], g[15:0]}, {16'd0, 16'(HALF)});
    cfg_corrupt <= 1'b1;
    cyc(2);
    lit(1, r, g);
    chk({r[15:0], g[15:0]}, {16'(HALF), 16'd0});
    cfg_corrupt <= 1'b0;
    pwr_cycle();
    cfg_loaded <= 1'b1;
    cyc(2);
    lit(1, r, g);
    chk({r[15:0], g[15:0]}, {16'd0, 16'd8});
    $display("test settings done");
  endtask

  task automatic t_alarm;
    int r, g;
    logic [31:0] v;
    alm(8'h70, 8'h03, 1'b0, 1'b0);
    chk({flag, flag_n, stop}, 3'b101);
    chk(pwr_led.red, 1'b1);
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[23:8], 16'h0370);
    cyc(20);
    chk({flag, flag_n, stop}, 3'b101);
    lit(2, r, g);
    chk(r, HALF);
    fault_clear_in <= 1'b1;
    cyc(2);
    chk({flag, flag_n, stop}, 3'b010);
    alm(8'h21, 8'h00, 1'b0, 1'b0);
    cyc(4);
    chk({flag, flag_n, stop}, 3'b101);
    fault_clear_in <= 1'b0;
    wr_reg(dafm_pkg::OFS_CMD, 32'h0000_0001);
    cyc(2);
    chk({flag, flag_n, stop}, 3'b010);
    alm(8'h22, 8'h00, 1'b0, 1'b0);
    pulse(0);
    chk({flag, flag_n, stop}, 3'b010);
    $display("test alarm done");
  endtask

  task automatic t_pco;
    logic [31:0] v;
    alm(8'h31, 8'h00, 1'b1, 1'b0);
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[1:0], 2'b11);
    fault_clear_in <= 1'b1;
    wr_reg(dafm_pkg::OFS_CMD, 32'h0000_0001);
    pulse(0);
    chk({flag, flag_n, stop}, 3'b101);
    fault_clear_in <= 1'b0;
    pwr_cycle();
    chk({flag, flag_n, stop}, 3'b010);
    $display("test power-cycle-only done");
  endtask

  task automatic t_abs;
    alm(8'h42, 8'h00, 1'b0, 1'b1);
    pulse(1);
    chk({flag, flag_n, stop}, 3'b010);
    alm(8'h42, 8'h00, 1'b0, 1'b1);
    pulse(2);
    chk({flag, flag_n, stop}, 3'b010);
    alm(8'h26, 8'h00, 1'b0, 1'b0);
    pulse(1);
    chk({flag, flag_n, stop}, 3'b101);
    pulse(0);
    $display("test position error done");
  endtask

  task automatic t_hist;
    logic [31:0] v, vb;
    wr_reg(dafm_pkg::OFS_CMD, 32'h0000_0002);
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[27:24], 4'h0);
    snap <= '{16'h0123, 16'h0456, 16'h0789, 16'hA5C3, 8'h96, 1'b0, 8'h00, 8'h02, 32'h8000_0001};
    for (int i = 0; i < 11; i++) alm(8'h10 + i, i, 1'b0, 1'b0);
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[27:24], 4'hA);
    wr_reg(dafm_pkg::OFS_HIST_SEL, 32'h0);
    rd_reg(8'h0C, v);
    chk(v, 32'h0002_0A1A);
    rd_reg(8'h10, v);
    chk(v, 32'h0456_0123);
    rd_reg(8'h14, v);
    chk(v, 32'hA5C3_0789);
    rd_reg(8'h18, v);
    chk(v, 32'h0096_FFFF);
    rd_reg(8'h1C, v);
    chk(v, 32'h8000_0001);
    wr_reg(dafm_pkg::OFS_HIST_SEL, 32'h9);
    rd_reg(8'h0C, v);
    chk(v[7:0], 8'h11);
    wr_reg(dafm_pkg::OFS_HIST_SEL, 32'hA);
    rd_reg(8'h0C, v);
    chk(v, 32'h0000_0000);
    snap.op_data_used <= 1'b1;
    snap.op_data_num <= 8'hFF;
    main_pwr_on <= 1'b0;
    pulse(3);
    main_pwr_on <= 1'b1;
    cyc(9);
    alm(8'h70, 8'h05, 1'b0, 1'b0);
    wr_reg(dafm_pkg::OFS_HIST_SEL, 32'h0);
    rd_reg(8'h18, v);
    chk(v, 32'h0096_00FF);
    rd_reg(8'h20, vb);
    rd_reg(8'h24, v);
    chk(v > 0 && v < vb, 1'b1);
    rd_reg(8'h28, v);
    chk(v > 0 && v < vb, 1'b1);
    rd_reg(8'h2C, v);
    chk(v, 32'h0000_0000);
    wr_reg(dafm_pkg::OFS_CMD, 32'h0000_0002);
    rd_reg(dafm_pkg::OFS_STATUS, v);
    chk(v[27:24], 4'h0);
    rd_reg(8'h0C, v);
    chk(v, 32'h0000_0000);
    $display("test history done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    hist_rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_link();
    t_cfg();
    t_alarm();
    t_pco();
    t_abs();
    t_hist();
    close_out();
  end

  // hang guard: far above the length of the whole sequence
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
endmodule // drive_alarm_fault_manager_test
